/* lpmc_pkg.sv */
// shared constants and types of the low power mode controller
package lpmc_pkg;

  // ****************************************************************
  // operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    LPMC_RESET,
    LPMC_ACTIVE,
    LPMC_STANDBY,
    LPMC_STOP,
    LPMC_WATCH,
    LPMC_SUBACTIVE,
    LPMC_SETTLE
  } lpmc_mode_t;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [3:0] LPMC_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] LPMC_ADDR_STATUS = 4'h4;
  localparam logic [3:0] LPMC_ADDR_EVENTS = 4'h8;

  localparam int LPMC_CTRL_HALT_SEL = 0;
  localparam int LPMC_CTRL_LOW_SPEED_ON_FLAG     = 1;
  localparam int LPMC_CTRL_DIRECT_TRANSFER_FLAG     = 2;
  localparam int LPMC_CTRL_IE       = 3;

  localparam int LPMC_ST_MODE_LSB   = 0;
  localparam int LPMC_ST_MAIN_OSC   = 4;
  localparam int LPMC_ST_SUB_OSC    = 5;
  localparam int LPMC_ST_CPU_CLK    = 6;
  localparam int LPMC_ST_PER_CLK    = 7;
  localparam int LPMC_ST_TB_CLK     = 8;
  localparam int LPMC_ST_HOLD       = 9;
  localparam int LPMC_ST_IO_HIZ     = 10;
  localparam int LPMC_ST_SUB_OPT    = 11;

  localparam logic [3:0] LPMC_CTRL_RESET = 4'h0;

  // ****************************************************************
  // interrupt source positions
  // ****************************************************************
  localparam int LPMC_NUM_IRQ  = 6;
  localparam int LPMC_IRQ_EXT0 = 0;
  localparam int LPMC_IRQ_TMRA = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int LPMC_CLK_MHZ        = 50;
  localparam int LPMC_OSC_SETTLE_NS  = 1000;
  localparam int LPMC_OSC_SETTLE_CYC =
    (LPMC_OSC_SETTLE_NS * LPMC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] LPMC_SETTLE_LOAD = 8'(LPMC_OSC_SETTLE_CYC - 1);

endpackage : lpmc_pkg

/* lpmc_gate_if.sv */
// mode to clock-and-hold decode carrier
`timescale 1ns/1ps
interface lpmc_gate_if;
  import lpmc_pkg::*;
  lpmc_mode_t mode;
  logic       main_osc;
  logic       cpu_clk;
  logic       cpu_on_sub;
  logic       per_clk;
  logic       tb_clk;
  logic       hold;
  logic       io_hiz;
  logic       blk_reset;
  logic       serial_irq_block;

  modport ctrl (output mode, input main_osc, cpu_clk, cpu_on_sub, per_clk, tb_clk,
                hold, io_hiz, blk_reset, serial_irq_block);
  modport gate (input mode, output main_osc, cpu_clk, cpu_on_sub, per_clk, tb_clk,
                hold, io_hiz, blk_reset, serial_irq_block);
endinterface : lpmc_gate_if

/* lpmc_gate.sv */
// per-mode clock enables and retention controls
`timescale 1ns/1ps
module lpmc_gate
  import lpmc_pkg::*;
(
  lpmc_gate_if.gate g
);

  always_comb
  begin
    g.main_osc         = 1'b1;
    g.cpu_clk          = 1'b0;
    g.cpu_on_sub       = 1'b0;
    g.per_clk          = 1'b0;
    g.tb_clk           = 1'b1;
    g.hold             = 1'b0;
    g.io_hiz           = 1'b0;
    g.blk_reset        = 1'b0;
    g.serial_irq_block = 1'b0;
    unique case (g.mode)
      LPMC_RESET:
      begin
        g.blk_reset = 1'b1;
      end
      LPMC_ACTIVE:
      begin
        g.cpu_clk = 1'b1;
        g.per_clk = 1'b1;
      end
      LPMC_STANDBY:
      begin
        g.per_clk = 1'b1;
        g.hold    = 1'b1;
      end
      LPMC_STOP:
      begin
        g.main_osc  = 1'b0;
        g.tb_clk    = 1'b0;
        g.blk_reset = 1'b1;
        g.io_hiz    = 1'b1;
      end
      LPMC_WATCH:
      begin
        // serial still shifts on an external clock, but raises nothing
        g.main_osc         = 1'b0;
        g.hold             = 1'b1;
        g.serial_irq_block = 1'b1;
      end
      LPMC_SUBACTIVE:
      begin
        g.main_osc   = 1'b0;
        g.cpu_clk    = 1'b1;
        g.cpu_on_sub = 1'b1;
        g.per_clk    = 1'b1;
      end
      LPMC_SETTLE:
      begin
        // main oscillator restarting, cpu still parked
        g.hold = 1'b1;
      end
    endcase
  end

endmodule : lpmc_gate

/* lpmc_ctrl.sv */
// operating mode controller with wishbone register slave
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter bit SUBACTIVE_OPTION = 1'b1
)
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // wishbone classic slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // cpu instruction strobes
  input  wire logic                    sleep_instr,
  input  wire logic                    stop_instr,
  // interrupt flags and masks of the interrupt controller
  input  wire logic [LPMC_NUM_IRQ-1:0] irq_flag,
  input  wire logic [LPMC_NUM_IRQ-1:0] irq_mask,
  input  wire logic                    irq_taken,
  // mode outputs
  output logic                         main_osc_en,
  output logic                         sub_osc_en,
  output logic                         cpu_clk_en,
  output logic                         cpu_on_sub_clk,
  output logic                         peripheral_clock_en,
  output logic                         timebase_clock_en,
  output logic                         state_hold,
  output logic                         io_hiz,
  output logic                         block_reset,
  output logic                         serial_irq_block,
  output logic                         resume_pulse,
  output logic                         irq_service,
  output logic                         instr_nop
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic any_pending(input logic [LPMC_NUM_IRQ-1:0] f,
                                       input logic [LPMC_NUM_IRQ-1:0] m);
    any_pending = |(f & ~m);
  endfunction : any_pending

  function automatic logic is_low_power(input lpmc_mode_t md);
    is_low_power = (md == LPMC_STANDBY) || (md == LPMC_WATCH) || (md == LPMC_STOP);
  endfunction : is_low_power

  // ****************************************************************
  // state
  // ****************************************************************
  lpmc_mode_t   mode_r;
  lpmc_mode_t   mode_nxt;
  lpmc_mode_t   settle_dest_r;
  lpmc_mode_t   settle_dest_nxt;
  logic [7:0]   settle_cnt_r;
  logic         halt_sel_r;
  logic         low_speed_on_flag_r;
  logic         direct_transfer_flag_r;
  logic         ie_r;
  logic         resume_r;
  logic         service_r;
  logic         nop_r;
  logic         ack_r;
  logic [31:0]  rdat_r;
  logic         any_irq;
  logic         watch_wake;
  logic         low_pwr_req;
  logic         wb_req;
  logic         wb_wr_ctrl;

  lpmc_gate_if g ();

  lpmc_gate u_gate (
    .g (g.gate)
  );

  assign g.mode      = mode_r;
  assign any_irq     = any_pending(irq_flag, irq_mask);
  assign watch_wake  = (irq_flag[LPMC_IRQ_EXT0] & ~irq_mask[LPMC_IRQ_EXT0]) |
                       (irq_flag[LPMC_IRQ_TMRA] & ~irq_mask[LPMC_IRQ_TMRA]);
  assign low_pwr_req = sleep_instr | stop_instr;
  assign wb_req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr_ctrl  = wb_req & wb_we_i & (wb_adr_i == LPMC_ADDR_CTRL) & wb_sel_i[0];

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  always_comb
  begin
    mode_nxt        = mode_r;
    settle_dest_nxt = settle_dest_r;
    unique case (mode_r)
      LPMC_RESET: mode_nxt = LPMC_ACTIVE;
      LPMC_ACTIVE:
      begin
        // a pending unmasked request with enable clear cancels the entry
        if (low_pwr_req && !(!ie_r && any_irq))
        begin
          if (sleep_instr)
            mode_nxt = LPMC_STANDBY;
          else if (halt_sel_r)
            mode_nxt = LPMC_WATCH;
          else
            mode_nxt = LPMC_STOP;
        end
      end
      LPMC_STANDBY:
        if (any_irq)
          mode_nxt = LPMC_ACTIVE;
      LPMC_STOP: mode_nxt = LPMC_STOP; // only reset leaves stop
      LPMC_WATCH:
      begin
        if (watch_wake)
        begin
          if (low_speed_on_flag_r && SUBACTIVE_OPTION)
            mode_nxt = LPMC_SUBACTIVE;
          else
          begin
            mode_nxt        = LPMC_SETTLE;
            settle_dest_nxt = LPMC_ACTIVE;
          end
        end
      end
      LPMC_SUBACTIVE:
      begin
        if (low_pwr_req && !(!ie_r && any_irq))
        begin
          if (direct_transfer_flag_r && !low_speed_on_flag_r)
          begin
            mode_nxt        = LPMC_SETTLE;
            settle_dest_nxt = LPMC_ACTIVE;
          end
          else
            mode_nxt = LPMC_WATCH;
        end
      end
      LPMC_SETTLE:
        if (settle_cnt_r == 8'h00)
          mode_nxt = settle_dest_r;
      default: mode_nxt = LPMC_RESET;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_r        <= LPMC_RESET;
      settle_dest_r <= LPMC_ACTIVE;
    end
    else
    begin
      mode_r        <= mode_nxt;
      settle_dest_r <= settle_dest_nxt;
    end
  end

  // main oscillator restart wait; the figure is a safe guess, not trimmed
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      settle_cnt_r <= 8'h00;
    else if (mode_r != LPMC_SETTLE)
      settle_cnt_r <= LPMC_SETTLE_LOAD;
    else if (settle_cnt_r != 8'h00)
      settle_cnt_r <= settle_cnt_r - 8'h01;
  end

  // ****************************************************************
  // wake and cancel strobes
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      resume_r  <= 1'b0;
      service_r <= 1'b0;
      nop_r     <= 1'b0;
    end
    else
    begin
      resume_r  <= (mode_nxt == LPMC_ACTIVE || mode_nxt == LPMC_SUBACTIVE) &&
                   (is_low_power(mode_r) || mode_r == LPMC_SETTLE);
      // a wake with enable clear leaves the request pending for later
      service_r <= (mode_r == LPMC_STANDBY) && (mode_nxt == LPMC_ACTIVE) && ie_r;
      nop_r     <= (mode_r == LPMC_ACTIVE || mode_r == LPMC_SUBACTIVE) &&
                   low_pwr_req && !ie_r && any_irq;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst || mode_r == LPMC_STOP)
    begin
      halt_sel_r <= LPMC_CTRL_RESET[LPMC_CTRL_HALT_SEL];
      low_speed_on_flag_r     <= LPMC_CTRL_RESET[LPMC_CTRL_LOW_SPEED_ON_FLAG];
      ie_r       <= LPMC_CTRL_RESET[LPMC_CTRL_IE];
    end
    else
    begin
      if (wb_wr_ctrl)
      begin
        halt_sel_r <= wb_dat_i[LPMC_CTRL_HALT_SEL];
        low_speed_on_flag_r     <= wb_dat_i[LPMC_CTRL_LOW_SPEED_ON_FLAG];
      end
      // taking an interrupt clears the enable; that wins over a write
      if (irq_taken)
        ie_r <= 1'b0;
      else if (wb_wr_ctrl)
        ie_r <= wb_dat_i[LPMC_CTRL_IE];
    end
  end

  // direct transfer flag is writable only in subactive, cleared in active
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      direct_transfer_flag_r <= LPMC_CTRL_RESET[LPMC_CTRL_DIRECT_TRANSFER_FLAG];
    else if (mode_r == LPMC_ACTIVE || mode_r == LPMC_STOP)
      direct_transfer_flag_r <= 1'b0;
    else if (wb_wr_ctrl && mode_r == LPMC_SUBACTIVE)
      direct_transfer_flag_r <= wb_dat_i[LPMC_CTRL_DIRECT_TRANSFER_FLAG];
  end

  // ****************************************************************
  // wishbone read path and ack
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= wb_req;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdat_r <= 32'h0000_0000;
    else if (wb_req && !wb_we_i)
    begin
      rdat_r <= 32'h0000_0000;
      unique case (wb_adr_i)
        LPMC_ADDR_CTRL:
          rdat_r[LPMC_CTRL_IE:LPMC_CTRL_HALT_SEL] <= {ie_r, direct_transfer_flag_r, low_speed_on_flag_r, halt_sel_r};
        LPMC_ADDR_STATUS:
        begin
          rdat_r[LPMC_ST_MODE_LSB +: 3] <= mode_r;
          rdat_r[LPMC_ST_SUB_OPT:LPMC_ST_MAIN_OSC] <= {SUBACTIVE_OPTION, io_hiz, state_hold,
            timebase_clock_en, peripheral_clock_en, cpu_clk_en, sub_osc_en, main_osc_en};
        end
        LPMC_ADDR_EVENTS:
          rdat_r[LPMC_NUM_IRQ-1:0] <= irq_flag & ~irq_mask;
        default: rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ****************************************************************
  // registered mode outputs
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      main_osc_en         <= 1'b1;
      sub_osc_en          <= 1'b1;
      cpu_clk_en          <= 1'b0;
      cpu_on_sub_clk      <= 1'b0;
      peripheral_clock_en <= 1'b0;
      timebase_clock_en   <= 1'b1;
      state_hold          <= 1'b0;
      io_hiz              <= 1'b0;
      block_reset         <= 1'b1;
      serial_irq_block    <= 1'b0;
    end
    else
    begin
      main_osc_en         <= g.main_osc;
      sub_osc_en          <= 1'b1;
      cpu_clk_en          <= g.cpu_clk;
      cpu_on_sub_clk      <= g.cpu_on_sub;
      peripheral_clock_en <= g.per_clk;
      timebase_clock_en   <= g.tb_clk;
      state_hold          <= g.hold;
      io_hiz              <= g.io_hiz;
      block_reset         <= g.blk_reset;
      serial_irq_block    <= g.serial_irq_block;
    end
  end

  assign resume_pulse = resume_r;
  assign irq_service  = service_r;
  assign instr_nop    = nop_r;

endmodule : lpmc_ctrl

/* lpmc_ctrl_checker.sv */
// port assertions of the low power mode controller
`timescale 1ns/1ps
module lpmc_ctrl_checker
  import lpmc_pkg::*;
#(
  parameter bit SUBACTIVE_OPTION = 1'b1
)
(
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [3:0]              wb_adr_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    sleep_instr,
  input wire logic                    stop_instr,
  input wire logic [LPMC_NUM_IRQ-1:0] irq_flag,
  input wire logic [LPMC_NUM_IRQ-1:0] irq_mask,
  input wire logic                    main_osc_en,
  input wire logic                    cpu_clk_en,
  input wire logic                    cpu_on_sub_clk,
  input wire logic                    peripheral_clock_en,
  input wire logic                    timebase_clock_en,
  input wire logic                    state_hold,
  input wire logic                    io_hiz,
  input wire logic                    block_reset,
  input wire logic                    serial_irq_block,
  input wire logic                    resume_pulse,
  input wire logic                    irq_service,
  input wire logic                    instr_nop
);
  // ****************************************************************
  // relations between ports
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  wire logic [LPMC_NUM_IRQ-1:0] pend = irq_flag & ~irq_mask;
  wire logic                    act  = cpu_clk_en & ~cpu_on_sub_clk;
  wire logic                    take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  a_sleep_standby: assert property (
    sleep_instr && act && !$past(sleep_instr | stop_instr) && pend == '0 |-> ##2
    !cpu_clk_en && state_hold && peripheral_clock_en && timebase_clock_en && main_osc_en)
    else $error("sleep in active did not give standby clocks");
  a_stop_halts: assert property (
    stop_instr && act && !$past(sleep_instr | stop_instr) && pend == '0 |-> ##2
    !main_osc_en && !cpu_clk_en && !peripheral_clock_en)
    else $error("stop in active left a clock running");
  a_hiz_reset: assert property (io_hiz |-> block_reset && !main_osc_en)
    else $error("high impedance without block reset");
  a_stop_locked: assert property (io_hiz |=> io_hiz)
    else $error("stop mode left without reset");
  a_tb_stop_only: assert property (!timebase_clock_en |-> io_hiz)
    else $error("timebase clock stopped outside stop mode");
  a_watch_clocks: assert property (
    serial_irq_block |-> !peripheral_clock_en && timebase_clock_en && !cpu_clk_en)
    else $error("serial interrupt blocked with wrong clocks");
  a_standby_wake: assert property (
    state_hold && peripheral_clock_en && !cpu_clk_en && pend != '0 |-> ##[1:3] cpu_clk_en)
    else $error("standby not left on pending request");
  a_service_resume: assert property (irq_service |-> resume_pulse ##1 cpu_clk_en)
    else $error("service without resume");
  a_nop_stays: assert property (
    instr_nop |-> $past(sleep_instr | stop_instr) && cpu_clk_en ##1 cpu_clk_en)
    else $error("cancelled instruction changed mode");
  a_reset_force: assert property (disable iff (1'b0)
    rst |=> block_reset && !cpu_clk_en && main_osc_en)
    else $error("reset did not force reset outputs");
  a_ack_latency: assert property (take |=> wb_ack_o)
    else $error("bus not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (
    take && !wb_we_i && wb_adr_i != 4'h0 && wb_adr_i != 4'h4 && wb_adr_i != 4'h8
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : lpmc_ctrl_checker

/* lpmc_ctrl_test.sv */
// self-checking bench of the low power mode controller
`timescale 1ns/1ps
module lpmc_ctrl_test;
  import lpmc_pkg::*;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_instr, stop_instr, irq_taken;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [LPMC_NUM_IRQ-1:0] irq_flag, irq_mask;
  logic main_osc_en, sub_osc_en, cpu_clk_en, cpu_on_sub_clk, peripheral_clock_en;
  logic timebase_clock_en, state_hold, io_hiz, block_reset, serial_irq_block;
  logic resume_pulse, irq_service, instr_nop;
  int fails, checked, cycles;

  lpmc_ctrl #(.SUBACTIVE_OPTION(1'b1)) dut (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleep_instr(sleep_instr), .stop_instr(stop_instr), .irq_flag(irq_flag),
    .irq_mask(irq_mask), .irq_taken(irq_taken), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .cpu_clk_en(cpu_clk_en), .cpu_on_sub_clk(cpu_on_sub_clk),
    .peripheral_clock_en(peripheral_clock_en), .timebase_clock_en(timebase_clock_en),
    .state_hold(state_hold), .io_hiz(io_hiz), .block_reset(block_reset),
    .serial_irq_block(serial_irq_block), .resume_pulse(resume_pulse),
    .irq_service(irq_service), .instr_nop(instr_nop));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  task print_verdict;
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // clock and hold flags packed: main sub cpu onsub per tb hold hiz
  function automatic logic [31:0] outs();
    return {24'h0, main_osc_en, sub_osc_en, cpu_clk_en, cpu_on_sub_clk,
            peripheral_clock_en, timebase_clock_en, state_hold, io_hiz};
  endfunction : outs

  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task instr(input logic stp);
    @(posedge clk_sys);
    if (stp) stop_instr <= 1'b1;
    else sleep_instr <= 1'b1;
    @(posedge clk_sys);
    stop_instr  <= 1'b0;
    sleep_instr <= 1'b0;
  endtask : instr

  task irq(input logic [5:0] f, input logic [5:0] m);
    @(posedge clk_sys);
    irq_flag <= f;
    irq_mask <= m;
  endtask : irq

  task do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    tick(3);
  endtask : do_reset

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, LPMC_ADDR_CTRL, 32'hf);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'hb);
    @(posedge clk_sys) irq_taken <= 1'b1;
    @(posedge clk_sys) irq_taken <= 1'b0;
    wb(1'b1, 4'hc, 32'hf);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h3);
    wb(1'b0, LPMC_ADDR_STATUS, 32'h0);
    check(rd & 32'hff7, 32'h9f1);
    wb(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    irq(6'h06, 6'h02);
    wb(1'b0, LPMC_ADDR_EVENTS, 32'h0);
    check(rd, 32'h4);
  endtask : t_regs

  task t_standby;
    irq(6'h20, 6'h3f);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h8);
    instr(1'b0);
    tick(2);
    check(outs(), 32'hce);
    irq(6'h20, 6'h1f);
    while (resume_pulse !== 1'b1) @(negedge clk_sys);
    check({31'h0, irq_service}, 32'h1);
    tick(1);
    check(outs(), 32'hec);
    irq(6'h20, 6'h3f);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h0);
    instr(1'b0);
    tick(2);
    irq(6'h20, 6'h1f);
    while (resume_pulse !== 1'b1) @(negedge clk_sys);
    check({31'h0, irq_service}, 32'h0);
    instr(1'b0);
    while (instr_nop !== 1'b1) @(negedge clk_sys);
    tick(1);
    check(outs(), 32'hec);
    irq(6'h00, 6'h00);
  endtask : t_standby

  task t_watch;
    wb(1'b1, LPMC_ADDR_CTRL, 32'h3);
    instr(1'b1);
    tick(2);
    check(outs(), 32'h46);
    check({31'h0, serial_irq_block}, 32'h1);
    irq(6'h02, 6'h00);
    tick(4);
    check(outs(), 32'h46);
    irq(6'h01, 6'h00);
    while (cpu_clk_en !== 1'b1) @(negedge clk_sys);
    tick(1);
    check(outs(), 32'h7c);
    irq(6'h00, 6'h00);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h5);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h5);
    instr(1'b0);
    while (!(cpu_clk_en === 1'b1 && cpu_on_sub_clk === 1'b0)) @(negedge clk_sys);
    tick(1);
    check(outs(), 32'hec);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd & 32'h4, 32'h0);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h3);
    instr(1'b1);
    tick(2);
    irq(6'h01, 6'h00);
    while (cpu_on_sub_clk !== 1'b1) @(negedge clk_sys);
    irq(6'h00, 6'h00);
    instr(1'b0);
    tick(2);
    check(outs(), 32'h46);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h1);
    irq(6'h04, 6'h00);
    while (!(cpu_clk_en === 1'b1 && cpu_on_sub_clk === 1'b0)) @(negedge clk_sys);
    tick(1);
    check(outs(), 32'hec);
    irq(6'h00, 6'h00);
  endtask : t_watch

  task t_stop;
    wb(1'b1, LPMC_ADDR_CTRL, 32'h8);
    instr(1'b1);
    tick(2);
    check(outs() & 32'hfd, 32'h41);
    irq(6'h05, 6'h00);
    tick(6);
    check({31'h0, block_reset}, 32'h1);
    check(outs() & 32'hfd, 32'h41);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    irq(6'h00, 6'h00);
    do_reset();
    check(outs(), 32'hec);
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, LPMC_ADDR_CTRL, 32'h8);
    instr(1'b0);
    tick(2);
    do_reset();
    wb(1'b0, LPMC_ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    check(outs(), 32'hec);
  endtask : t_stop

  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, sleep_instr, stop_instr, irq_taken} = 7'h40;
    {wb_adr_i, wb_dat_i, irq_flag, irq_mask} = '0;
    wb_sel_i = 4'hf;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    tick(3);
    t_regs();
    t_standby();
    t_watch();
    t_stop();
    print_verdict();
  end
endmodule : lpmc_ctrl_test

bind lpmc_ctrl lpmc_ctrl_checker #(.SUBACTIVE_OPTION(SUBACTIVE_OPTION)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sleep_instr(sleep_instr), .stop_instr(stop_instr), .irq_flag(irq_flag),
  .irq_mask(irq_mask), .main_osc_en(main_osc_en), .cpu_clk_en(cpu_clk_en),
  .cpu_on_sub_clk(cpu_on_sub_clk), .peripheral_clock_en(peripheral_clock_en),
  .timebase_clock_en(timebase_clock_en), .state_hold(state_hold), .io_hiz(io_hiz),
  .block_reset(block_reset), .serial_irq_block(serial_irq_block),
  .resume_pulse(resume_pulse), .irq_service(irq_service), .instr_nop(instr_nop));
